// file: src/clk_ctrl_defines.vh
// How it works
// - sample clock divided by 1, 2, 4 or 8 from the ratio register
// - divided clock taken from a counter bit, so 50% duty between sync loads; held low in bypass
// - per-channel half-cycle phase delay; changing it leaves the link alone
// - sync enabled: a system reference edge loads the divider with a preset
// - fine delay enabled by bit 0, amount from an 8-bit per-channel value
// - fine delay code maps to -151.7 to +150 ps in 1.7 ps steps
// - fine delay takes effect on the cycle after the enabling write
// - turning fine delay on pulses a datapath reset; value change does not
// - active-high power pin, default power-down; registers can also power down
// - power-down drops the serial output link
// - standby keeps link up, sends zero samples or /K/ when fill bit set
// - diode enable is bit 0 of a per-channel register, channel A selected
// - fast-detect A pin function from bits 2:0; one code routes the diode
`ifndef CLK_CTRL_DEFINES_VH
`define CLK_CTRL_DEFINES_VH
`define REG_CHAN_INDEX 15'h0008
`define REG_TEMP_DIODE 15'h0028
`define REG_POWER_MODE 15'h003F
`define REG_PIN_FUNC 15'h0040
`define REG_DIV_RATIO 15'h010B
`define REG_DIV_HALF 15'h010C
`define REG_DIV_SYNC 15'h010D
`define REG_FINE_EN 15'h0117
`define REG_FINE_VAL 15'h0118
`define REG_STBY_FILL 15'h0571
`define RST_CHAN_INDEX 8'h03
`define RST_ZERO 8'h00
`define SYNC_EN_BIT 7
`define FILL_K_BIT 7
`define FINE_EN_BIT 0
`define DIODE_EN_BIT 0
`define PIN_MODE_HI 7
`define PIN_MODE_LO 6
`define PIN_MODE_PDWN 2'h0
`define PIN_MODE_STBY 2'h1
`define PWR_NORMAL 2'h0
`define PWR_STANDBY 2'h1
`define FD_A_DIODE 3'h6
`define FINE_ZERO_CODE 8'h59
`define FINE_MAX_CODE 8'hB1
`define CLK_MHZ 100
`define DP_RESET_NS 40
`define DP_RESET_CYC ((`DP_RESET_NS * `CLK_MHZ + 999) / 1000)
`endif

// file: src/adc_clock_divide_delay_power_ctrl.v
`timescale 1ns/100ps
`include "clk_ctrl_defines.vh"
module adc_clock_divide_delay_power_ctrl #(
  parameter DP_RESET_CYCLES = `DP_RESET_CYC
) (
  input wire sys_clk,
  input wire rst_n,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_sdi,
  output reg spi_sdo,
  output reg spi_sdo_oe,
  input wire power_down_standby_pin,
  input wire system_reference_pulse,
  output reg div_clk,
  output reg div_bypass,
  output reg half_delay_a,
  output reg half_delay_b,
  output reg fine_delay_en_a,
  output reg fine_delay_en_b,
  output reg [8:0] fine_shift_a,
  output reg [8:0] fine_shift_b,
  output reg datapath_reset,
  output reg core_power_on,
  output reg link_enable,
  output reg link_fill_zero,
  output reg link_fill_k,
  output reg diode_enable,
  output reg [2:0] fast_detect_out_a_func,
  output reg diode_on_fast_detect_a
);

  // signed shift in 1.7 ps steps; code 0x59 is near zero skew
  function [8:0] fine_shift;
    input [7:0] code;
    reg [7:0] c;
    begin
      c = (code > `FINE_MAX_CODE) ? `FINE_MAX_CODE : code;
      fine_shift = {1'b0, c} - {1'b0, `FINE_ZERO_CODE};
    end
  endfunction

  // ratio code 1..3 picks counter bit, code 0 holds low; bit k gives divide by 2^(k+1)
  function div_level;
    input [1:0] ratio;
    input [2:0] cnt;
    begin
      case (ratio)
        2'h1: div_level = cnt[0];
        2'h2: div_level = cnt[1];
        2'h3: div_level = cnt[2];
        default: div_level = 1'b0;
      endcase
    end
  endfunction

  // pin synchronisers, two stages before any logic looks
  reg cs_m, cs_s, sclk_m, sclk_s, sclk_d, sdi_m, sdi_s;
  reg pin_m, pin_s, sref_m, sref_s, sref_d;
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
      pin_m <= 1'b0;
      pin_s <= 1'b0;
      sref_m <= 1'b0;
      sref_s <= 1'b0;
      sref_d <= 1'b0;
    end
    else
    begin
      cs_m <= spi_cs_n;
      cs_s <= cs_m;
      sclk_m <= spi_sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sdi_m <= spi_sdi;
      sdi_s <= sdi_m;
      pin_m <= power_down_standby_pin;
      pin_s <= pin_m;
      sref_m <= system_reference_pulse;
      sref_s <= sref_m;
      sref_d <= sref_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire sref_edge = sref_s & ~sref_d;

  // register storage; per-channel copies sit at index 0 (A) and 1 (B)
  reg [7:0] chan_index, power_mode, pin_func, div_ratio, div_half, div_sync, stby_fill;
  reg [7:0] temp_diode [0:1];
  reg [7:0] fine_en [0:1];
  reg [7:0] fine_val [0:1];

  // serial frame: 16-bit instruction (bit 15 = read), then 8 data bits
  reg [22:0] shift;
  reg [4:0] bit_cnt;
  reg rd_active;
  reg [7:0] rd_shift;
  wire [23:0] word = {shift, sdi_s};
  wire wr_en = ~cs_s & sclk_rise & (bit_cnt == 5'h17) & ~rd_active;
  wire [14:0] wr_addr = word[22:8];
  wire [7:0] wr_data = word[7:0];
  wire [14:0] rd_addr = word[14:0];
  // local reads come from channel A when it is selected, else from B
  wire rd_ch = ~chan_index[0];

  // read mux; unmapped addresses read as zero
  reg [7:0] rd_mux;
  always @*
  begin
    case (rd_addr)
      `REG_CHAN_INDEX: rd_mux = chan_index;
      `REG_TEMP_DIODE: rd_mux = temp_diode[rd_ch];
      `REG_POWER_MODE: rd_mux = power_mode;
      `REG_PIN_FUNC: rd_mux = pin_func;
      `REG_DIV_RATIO: rd_mux = div_ratio;
      `REG_DIV_HALF: rd_mux = div_half;
      `REG_DIV_SYNC: rd_mux = div_sync;
      `REG_FINE_EN: rd_mux = fine_en[rd_ch];
      `REG_FINE_VAL: rd_mux = fine_val[rd_ch];
      `REG_STBY_FILL: rd_mux = stby_fill;
      default: rd_mux = 8'h00;
    endcase
  end

  // serial shifter; sdo changes on falling sclk so the host samples on rising
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift <= 23'h000000;
      bit_cnt <= 5'h00;
      rd_active <= 1'b0;
      rd_shift <= 8'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end
    else if (cs_s)
    begin
      bit_cnt <= 5'h00;
      rd_active <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end
    else
    begin
      if (sclk_rise && bit_cnt != 5'h18)
      begin
        shift <= word[22:0];
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == 5'h0F && word[15])
        begin
          rd_active <= 1'b1;
          rd_shift <= rd_mux;
        end
      end
      if (sclk_fall && rd_active)
      begin
        spi_sdo_oe <= (bit_cnt >= 5'h10) && (bit_cnt < 5'h18);
        spi_sdo <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end

  // channels targeted by a local write
  wire [1:0] wr_ch = chan_index[1:0];
  // enable rising in any written channel asks for a datapath reset
  wire fine_turn_on = wr_en && (wr_addr == `REG_FINE_EN) && wr_data[`FINE_EN_BIT] &&
    ((wr_ch[0] && !fine_en[0][`FINE_EN_BIT]) || (wr_ch[1] && !fine_en[1][`FINE_EN_BIT]));

  // register writes
  // reset defaults
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_index <= `RST_CHAN_INDEX;
      power_mode <= `RST_ZERO;
      pin_func <= `RST_ZERO;
      div_ratio <= `RST_ZERO;
      div_half <= `RST_ZERO;
      div_sync <= `RST_ZERO;
      stby_fill <= `RST_ZERO;
      temp_diode[0] <= `RST_ZERO;
      temp_diode[1] <= `RST_ZERO;
      fine_en[0] <= `RST_ZERO;
      fine_en[1] <= `RST_ZERO;
      fine_val[0] <= `RST_ZERO;
      fine_val[1] <= `RST_ZERO;
    end
    else if (wr_en)
    begin
      case (wr_addr)
        `REG_CHAN_INDEX: chan_index <= wr_data;
        `REG_POWER_MODE: power_mode <= wr_data;
        `REG_PIN_FUNC: pin_func <= wr_data;
        `REG_DIV_RATIO: div_ratio <= wr_data;
        `REG_DIV_HALF: div_half <= wr_data;
        `REG_DIV_SYNC: div_sync <= wr_data;
        `REG_STBY_FILL: stby_fill <= wr_data;
        `REG_TEMP_DIODE:
        begin
          if (wr_ch[0]) temp_diode[0] <= wr_data;
          if (wr_ch[1]) temp_diode[1] <= wr_data;
        end
        `REG_FINE_EN:
        begin
          if (wr_ch[0]) fine_en[0] <= wr_data;
          if (wr_ch[1]) fine_en[1] <= wr_data;
        end
        `REG_FINE_VAL:
        begin
          if (wr_ch[0]) fine_val[0] <= wr_data;
          if (wr_ch[1]) fine_val[1] <= wr_data;
        end
        default: chan_index <= chan_index;
      endcase
    end
  end

  // divider counter; runs freely apart from sync loads, so every ratio change stays aligned
  reg [2:0] div_cnt;
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= 3'h0;
    else if (sref_edge && div_sync[`SYNC_EN_BIT])
      div_cnt <= div_sync[2:0];
    else
      div_cnt <= div_cnt + 3'h1;
  end

  // divided clock and per-channel phase outputs
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_clk <= 1'b0;
      div_bypass <= 1'b1;
      half_delay_a <= 1'b0;
      half_delay_b <= 1'b0;
    end
    else
    begin
      div_bypass <= (div_ratio[1:0] == 2'h0);
      div_clk <= div_level(div_ratio[1:0], div_cnt);
      half_delay_a <= div_half[0];
      half_delay_b <= div_half[1];
    end
  end

  // fine delay outputs follow the registers one cycle after the write
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fine_delay_en_a <= 1'b0;
      fine_delay_en_b <= 1'b0;
      fine_shift_a <= 9'h000;
      fine_shift_b <= 9'h000;
    end
    else
    begin
      fine_delay_en_a <= fine_en[0][`FINE_EN_BIT];
      fine_delay_en_b <= fine_en[1][`FINE_EN_BIT];
      fine_shift_a <= fine_shift(fine_val[0]);
      fine_shift_b <= fine_shift(fine_val[1]);
    end
  end

  // datapath reset pulse; a value-only write never starts it
  reg [7:0] dp_cnt;
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_cnt <= 8'h00;
      datapath_reset <= 1'b0;
    end
    else
    begin
      if (fine_turn_on)
        dp_cnt <= DP_RESET_CYCLES[7:0];
      else if (dp_cnt != 8'h00)
        dp_cnt <= dp_cnt - 8'h01;
      datapath_reset <= fine_turn_on || (dp_cnt > 8'h01);
    end
  end

  // power state: pin mode field picks what the pin does
  wire [1:0] pin_mode = pin_func[`PIN_MODE_HI:`PIN_MODE_LO];
  wire pin_pdwn = pin_s && (pin_mode == `PIN_MODE_PDWN);
  wire pin_stby = pin_s && (pin_mode == `PIN_MODE_STBY);
  wire reg_pdwn = (power_mode[1:0] != `PWR_NORMAL) && (power_mode[1:0] != `PWR_STANDBY);
  wire reg_stby = (power_mode[1:0] == `PWR_STANDBY);
  wire go_pdwn = pin_pdwn || reg_pdwn;
  wire go_stby = !go_pdwn && (pin_stby || reg_stby);

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_power_on <= 1'b1;
      link_enable <= 1'b1;
      link_fill_zero <= 1'b0;
      link_fill_k <= 1'b0;
    end
    else
    begin
      core_power_on <= !go_pdwn && !go_stby;
      link_enable <= !go_pdwn;
      link_fill_zero <= go_stby && !stby_fill[`FILL_K_BIT];
      link_fill_k <= go_stby && stby_fill[`FILL_K_BIT];
    end
  end

  // temperature diode and fast-detect A pin routing
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      diode_enable <= 1'b0;
      fast_detect_out_a_func <= 3'h0;
      diode_on_fast_detect_a <= 1'b0;
    end
    else
    begin
      diode_enable <= temp_diode[0][`DIODE_EN_BIT];
      fast_detect_out_a_func <= pin_func[2:0];
      diode_on_fast_detect_a <= (pin_func[2:0] == `FD_A_DIODE) && temp_diode[0][`DIODE_EN_BIT];
    end
  end

endmodule // adc_clock_divide_delay_power_ctrl

// file: verification/spi_host_model.sv
`timescale 1ns/100ps
// serial configuration host; each sclk phase spans 4 sys_clk
module spi_host_model (
  input wire sys_clk,
  output reg spi_cs_n = 1'b1,
  output reg spi_sclk = 1'b0,
  output reg spi_sdi = 1'b0,
  input wire spi_sdo,
  input wire spi_sdo_oe
);
  // one 24-bit frame, msb first; sdi flips once idle so no stale bit looks valid
  task xfer(input [23:0] f, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      @(posedge sys_clk) #1 spi_cs_n = 1'b0;
      for (i = 23; i >= 0; i = i - 1)
      begin
        spi_sclk = 1'b0;
        spi_sdi = f[i];
        repeat (4) @(posedge sys_clk);
        #1 rd = {rd[6:0], spi_sdo & spi_sdo_oe};
        spi_sclk = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
      end
      spi_sclk = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      // return off the edge so callers never race the registered outputs
      repeat (8) @(posedge sys_clk);
      #1;
    end
  endtask
endmodule // spi_host_model

// file: verification/adc_clock_divide_delay_power_ctrl_asserts.sv
`timescale 1ns/100ps
module clk_ctrl_checker #(
  parameter DP_RESET_CYCLES = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire div_clk,
  input wire div_bypass,
  input wire fine_delay_en_a,
  input wire fine_delay_en_b,
  input wire datapath_reset,
  input wire core_power_on,
  input wire link_enable,
  input wire link_fill_zero,
  input wire link_fill_k,
  input wire diode_enable,
  input wire [2:0] fast_detect_out_a_func,
  input wire diode_on_fast_detect_a
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  reg [7:0] hi_cnt;
  // length of the running datapath reset pulse
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= datapath_reset ? hi_cnt + 8'h01 : 8'h00;
  end
  // output relations
  AST_RST_VAL: assert property ($rose(rst_n) |-> div_bypass && core_power_on && link_enable)
    else $error("bad state after reset");
  AST_BYP_LOW: assert property (div_bypass |-> !div_clk)
    else $error("divided clock active in bypass");
  AST_PULSE_LEN: assert property ($fell(datapath_reset) |-> hi_cnt == DP_RESET_CYCLES)
    else $error("datapath reset length wrong");
  // reset pulse starts one cycle ahead of the registered enable
  AST_EN_RESET: assert property ($rose(fine_delay_en_a) || $rose(fine_delay_en_b)
    |-> $past(datapath_reset)) else $error("enable gave no reset");
  AST_RST_CAUSE: assert property ($rose(datapath_reset)
    |=> $rose(fine_delay_en_a) || $rose(fine_delay_en_b)) else $error("stray reset");
  AST_PD_CORE: assert property (!link_enable |-> !core_power_on)
    else $error("core on with link down");
  AST_FILL: assert property (link_enable && !core_power_on |-> link_fill_zero ^ link_fill_k)
    else $error("standby fill wrong");
  AST_DIODE: assert property (diode_on_fast_detect_a ==
    (diode_enable && fast_detect_out_a_func == 3'h6)) else $error("diode routing wrong");
  cover property ($rose(datapath_reset));
  cover property (link_enable && !core_power_on && link_fill_k);
  cover property ($rose(diode_on_fast_detect_a));
endmodule // clk_ctrl_checker
bind adc_clock_divide_delay_power_ctrl clk_ctrl_checker #(.DP_RESET_CYCLES(DP_RESET_CYCLES)) chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .div_clk(div_clk), .div_bypass(div_bypass),
  .fine_delay_en_a(fine_delay_en_a), .fine_delay_en_b(fine_delay_en_b),
  .datapath_reset(datapath_reset), .core_power_on(core_power_on), .link_enable(link_enable),
  .link_fill_zero(link_fill_zero), .link_fill_k(link_fill_k), .diode_enable(diode_enable),
  .fast_detect_out_a_func(fast_detect_out_a_func),
  .diode_on_fast_detect_a(diode_on_fast_detect_a));

// file: verification/tb_adc_clock_divide_delay_power_ctrl.sv
`timescale 1ns/100ps
module tb_adc_clock_divide_delay_power_ctrl;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg pin = 1'b0;
  reg sref = 1'b0;
  wire cs_n, sclk, sdi, sdo, oe, dclk, byp, ha, hb, fea, feb, dpr, core, link, fz, fk, den, dfd;
  wire [8:0] sha, shb;
  wire [2:0] func;
  integer n_fail = 0, comparisons = 0, dp_cnt = 0, k, d, hi, lo, t;
  reg [7:0] rd, c, s1, s2;
  localparam [149:0] ADDRS = {15'h008, 15'h028, 15'h03F, 15'h040, 15'h10B, 15'h10C,
    15'h10D, 15'h117, 15'h118, 15'h571};
  localparam [31:0] CODES = 32'hFFB15900;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // tally of datapath reset cycles
  always @(posedge sys_clk)
    if (dpr === 1'b1)
      dp_cnt <= dp_cnt + 1;
  adc_clock_divide_delay_power_ctrl #(.DP_RESET_CYCLES(4)) adc_clock_divide_delay_power_ctrl_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi),
    .spi_sdo(sdo), .spi_sdo_oe(oe), .power_down_standby_pin(pin),
    .system_reference_pulse(sref), .div_clk(dclk), .div_bypass(byp), .half_delay_a(ha),
    .half_delay_b(hb), .fine_delay_en_a(fea), .fine_delay_en_b(feb), .fine_shift_a(sha),
    .fine_shift_b(shb), .datapath_reset(dpr), .core_power_on(core), .link_enable(link),
    .link_fill_zero(fz), .link_fill_k(fk), .diode_enable(den),
    .fast_detect_out_a_func(func), .diode_on_fast_detect_a(dfd));
  spi_host_model spi_host_model_i (.sys_clk(sys_clk), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe));
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk_out(input [8:0] got, input [8:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_reg(input [7:0] got, input [7:0] exp);
    chk_out({1'b0, got}, {1'b0, exp});
  endtask
  task wr(input [14:0] a, input [7:0] v);
    spi_host_model_i.xfer({1'b0, a, v}, rd);
  endtask
  task rdr(input [14:0] a, input [7:0] e);
    begin
      spi_host_model_i.xfer({1'b1, a, 8'h00}, rd);
      chk_reg(rd, e);
    end
  endtask
  // clamped fine delay steps
  function [8:0] exp_shift(input [7:0] v);
    exp_shift = ((v > 8'hB1) ? 9'h0B1 : {1'b0, v}) - 9'h059;
  endfunction
  // divide-by-8 level seen 3 cycles on from a sync load of preset p
  function [7:0] exp_sync(input [2:0] p);
    integer i;
    reg [2:0] v;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        v = p + 3'h3 + i[2:0];
        exp_sync[i] = v[2];
      end
    end
  endfunction
  // high and low run of one divided period, bounded
  task measure;
    begin
      for (t = 0; t < 64 && dclk !== 1'b0; t = t + 1) @(posedge sys_clk) #1;
      for (t = t; t < 64 && dclk !== 1'b1; t = t + 1) @(posedge sys_clk) #1;
      for (lo = t; t < 64 && dclk === 1'b1; t = t + 1) @(posedge sys_clk) #1;
      for (hi = t - lo, lo = t; t < 64 && dclk === 1'b0; t = t + 1) @(posedge sys_clk) #1;
      lo = t - lo;
      if (t >= 64)
      begin
        n_fail = n_fail + 1;
        summarize;
      end
    end
  endtask
  // sync pulse, then 8 samples of the divided clock
  task sync_run(output [7:0] s);
    integer i;
    begin
      @(posedge sys_clk) #1 sref = 1'b1;
      repeat (6) @(posedge sys_clk);
      for (i = 0; i < 8; i = i + 1)
        @(posedge sys_clk) #1 s[i] = dclk;
      #1 sref = 1'b0;
    end
  endtask
  task pw(input [23:0] r, input [3:0] e);
    begin
      wr(15'h03F, r[23:16]);
      wr(15'h040, r[15:8]);
      wr(15'h571, r[7:0]);
      @(posedge sys_clk) #1 pin = e[3];
      repeat (5) @(posedge sys_clk);
      chk_out({7'h00, core, link}, {7'h00, e[2:1]});
      if (e[2:1] == 2'b01)
        chk_out({7'h00, fz, fk}, {7'h00, !e[0], e[0]});
    end
  endtask
  initial
  begin
    c = $urandom(2591);
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk_out({4'h0, byp, dclk, dpr, core, link}, 9'h013);
    for (k = 0; k < 10; k = k + 1)
      rdr(ADDRS[k*15 +: 15], (k == 9) ? 8'h03 : 8'h00);
    wr(15'h7FF, 8'h5A);
    rdr(15'h7FF, 8'h00);
    c = $urandom;
    wr(15'h118, c);
    rdr(15'h118, c);
    $display("registers test done");
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(15'h10B, k[7:0]);
      if (k == 0)
        chk_out({7'h00, byp, dclk}, 9'h002);
      else
      begin
        measure;
        chk_out({hi[7:0], byp}, {8'h01 << (k - 1), 1'b0});
        chk_out(lo[8:0], 9'h001 << (k - 1));
      end
    end
    c = $urandom;
    wr(15'h10D, {5'h10, c[2:0]});
    sync_run(s1);
    wr(15'h10D, {5'h10, ~c[2], c[1:0]});
    sync_run(s2);
    chk_out({1'b0, s2}, {1'b0, ~s1});
    chk_out({1'b0, s1}, {1'b0, exp_sync(c[2:0])});
    $display("divider test done");
    d = dp_cnt;
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(15'h10C, k[7:0]);
      chk_out({7'h00, hb, ha}, k[8:0]);
    end
    chk_out({link, dp_cnt[7:0] - d[7:0]}, 9'h100);
    wr(15'h008, 8'h01);
    d = dp_cnt;
    wr(15'h117, 8'h01);
    chk_out({fea, feb, dp_cnt[6:0] - d[6:0]}, {2'b10, 7'h04});
    for (k = 0; k < 6; k = k + 1)
    begin
      c = $urandom;
      if (k < 4)
        c = CODES[k*8 +: 8];
      d = dp_cnt;
      wr(15'h118, c);
      chk_out(sha, exp_shift(c));
      chk_out({feb, dp_cnt[7:0] - d[7:0]}, 9'h000);
    end
    d = dp_cnt;
    wr(15'h117, 8'h01);
    wr(15'h008, 8'h02);
    wr(15'h117, 8'h01);
    chk_out({fea, feb, dp_cnt[6:0] - d[6:0]}, {2'b11, 7'h04});
    wr(15'h118, 8'hB1);
    chk_out(shb, 9'h058);
    chk_out(sha, exp_shift(c));
    $display("delay test done");
    pw(24'h000000, 4'b1000);
    pw(24'h004000, 4'b1010);
    pw(24'h004080, 4'b1011);
    pw(24'h018080, 4'b0011);
    pw(24'h028000, 4'b0000);
    pw(24'h008000, 4'b1110);
    pw(24'h00C000, 4'b1110);
    pw(24'h03C000, 4'b1000);
    $display("power test done");
    wr(15'h040, 8'h06);
    wr(15'h008, 8'h01);
    wr(15'h028, 8'h01);
    chk_out({5'h00, func, den, dfd}, 9'h01B);
    $display("diode test done");
    summarize;
  end
endmodule // tb_adc_clock_divide_delay_power_ctrl
